// ===== qbio_pkg.sv
// Package of constants for the quasi-bidirectional I/O ports
package qbio_pkg;
  localparam int PORT_W = 8;
  localparam int NARROW_W = 4;
  localparam int NPORTS = 5;
  localparam int STATE_W = 4;
  // Port indices
  localparam logic [2:0] PORT_OD = 3'h0;
  localparam logic [2:0] PORT_ONE = 3'h1;
  localparam logic [2:0] PORT_HA = 3'h2;
  localparam logic [2:0] PORT_THREE = 3'h3;
  localparam logic [2:0] PORT_FOUR = 3'h4;
  // Reset value of every port register: all lines input, pull-down off
  localparam logic [7:0] PORT_RESET = 8'hFF;
  localparam logic [7:0] ALL_ONES = 8'hFF;
  // Machine cycle states, oscillator periods per machine cycle
  localparam logic [3:0] STATE_FIRST = 4'h1;
  localparam logic [3:0] STATE_NINE = 4'h9;
  localparam logic [3:0] STATE_TEN = 4'hA;
  localparam logic [3:0] FINAL_STATE = 4'hC;
endpackage

// ===== qbio_sync.sv
// Two-stage synchroniser for a vector of pin levels
`timescale 1ns/1ps
module qbio_sync #(
  parameter int W = 8
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  typedef struct packed {
    logic [W-1:0] stage1;
    logic [W-1:0] stage2;
  } qbio_sync_s;

  qbio_sync_s st_reg;
  qbio_sync_s st_next;

  // Shift the pin levels through two flops
  always_comb begin
    st_next = st_reg;
    st_next.stage1 = async_in;
    st_next.stage2 = st_reg.stage1;
  end

  // Register the state; reset to the idle-high level of the lines
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      st_reg <= '1;
    end else begin
      st_reg <= st_next;
    end
  end

  assign sync_out = st_reg.stage2;
endmodule

// ===== qbio_ports.sv
// Quasi-bidirectional I/O port block: four 8-bit ports and one 4-bit port
//
// Summary of operation
// - There are 36 lines in four byte ports and one nibble port, each line input or output on its own.
// - A register bit at zero turns on the pull-down and drives the pin low.
// - A register bit at one turns off the pull-down, and all ports but the open-drain one pull up weakly.
// - Reset sets every register bit to one, so every line is an input.
// - Each register bit is a flop loaded from the data bus on that port's write strobe.
// - A read returns either the register or the pin level, chosen by the read type.
// - In plain I/O use the open-drain port has no pull-up and floats when its bit is one.
// - The open-drain port's active pull-up is used only in bus mode: external bus selected or an external data move.
// - During an external data move input the open-drain register is forced to all ones.
// - The high-address port output picks register or A8-A15, the open-drain port register or address/data.
// - In bus mode both registers leave the output stage, open-drain register goes to ones, high-address keeps.
// - A written value lands in the register at once and reaches the pin after the next final state.
// - Pins are sampled in state nine for ports zero and one, state ten for ports two and three, the final state for port four.
`timescale 1ns/1ps
module qbio_ports (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic osc_state_en,
  input wire logic [2:0] port_sel,
  input wire logic port_wr,
  input wire logic [7:0] wr_data,
  input wire logic rd_pin_sel,
  output logic [7:0] rd_data,
  input wire logic external_access_select,
  input wire logic external_data_move,
  input wire logic bus_addr_phase,
  input wire logic bus_drive,
  input wire logic [7:0] bus_addr_lo,
  input wire logic [7:0] bus_addr_hi,
  input wire logic [7:0] bus_wr_data,
  output logic [7:0] bus_rd_data,
  input wire logic [7:0] open_drain_bus_port_in,
  output logic [7:0] open_drain_bus_port_out,
  output logic [7:0] open_drain_bus_port_oe_n,
  output logic [7:0] open_drain_bus_port_pullup,
  input wire logic [7:0] port_one_in,
  output logic [7:0] port_one_out,
  output logic [7:0] port_one_oe_n,
  input wire logic [7:0] high_address_port_in,
  output logic [7:0] high_address_port_out,
  output logic [7:0] high_address_port_oe_n,
  input wire logic [7:0] port_three_in,
  output logic [7:0] port_three_out,
  output logic [7:0] port_three_oe_n,
  input wire logic [3:0] port_four_in,
  output logic [3:0] port_four_out,
  output logic [3:0] port_four_oe_n,
  output logic [3:0] machine_state
);
  typedef struct packed {
    logic [3:0] phase;
    logic [7:0] latch_od;
    logic [7:0] latch_one;
    logic [7:0] latch_ha;
    logic [7:0] latch_three;
    logic [3:0] latch_four;
    logic [7:0] stage_od;
    logic [7:0] stage_one;
    logic [7:0] stage_ha;
    logic [7:0] stage_three;
    logic [3:0] stage_four;
    logic [7:0] samp_od;
    logic [7:0] samp_one;
    logic [7:0] samp_ha;
    logic [7:0] samp_three;
    logic [3:0] samp_four;
    logic [7:0] rd;
    logic [7:0] bus_rd;
  } qbio_state_s;

  qbio_state_s st_reg;
  qbio_state_s st_next;
  logic [7:0] sy_od;
  logic [7:0] sy_one;
  logic [7:0] sy_ha;
  logic [7:0] sy_three;
  logic [3:0] sy_four;
  logic bus_mode;

  // Bus mode hands both bus ports to the external memory interface
  assign bus_mode = !external_access_select || external_data_move;

  // Pin synchronisers ahead of the read-pin path
  qbio_sync #(.W(qbio_pkg::PORT_W)) u_sync_od (
    .clock(clock), .rst_n(rst_n),
    .async_in(open_drain_bus_port_in), .sync_out(sy_od));
  qbio_sync #(.W(qbio_pkg::PORT_W)) u_sync_one (
    .clock(clock), .rst_n(rst_n),
    .async_in(port_one_in), .sync_out(sy_one));
  qbio_sync #(.W(qbio_pkg::PORT_W)) u_sync_ha (
    .clock(clock), .rst_n(rst_n),
    .async_in(high_address_port_in), .sync_out(sy_ha));
  qbio_sync #(.W(qbio_pkg::PORT_W)) u_sync_three (
    .clock(clock), .rst_n(rst_n),
    .async_in(port_three_in), .sync_out(sy_three));
  qbio_sync #(.W(qbio_pkg::NARROW_W)) u_sync_four (
    .clock(clock), .rst_n(rst_n),
    .async_in(port_four_in), .sync_out(sy_four));

  // Widen the nibble port to a byte with unused bits at zero
  function automatic logic [7:0] qbio_widen(input logic [3:0] v);
    qbio_widen = {4'h0, v};
  endfunction

  // Next-state logic: state counter, latches, sampling, output stage, reads
  always_comb begin
    st_next = st_reg;
    if (osc_state_en) begin
      if (st_reg.phase == qbio_pkg::FINAL_STATE) begin
        st_next.phase = qbio_pkg::STATE_FIRST;
      end else begin
        st_next.phase = st_reg.phase + 4'h1;
      end
      // Output stage picks up latches at the final state only
      if (st_reg.phase == qbio_pkg::FINAL_STATE) begin
        st_next.stage_od = st_reg.latch_od;
        st_next.stage_one = st_reg.latch_one;
        st_next.stage_ha = st_reg.latch_ha;
        st_next.stage_three = st_reg.latch_three;
        st_next.stage_four = st_reg.latch_four;
        st_next.samp_four = sy_four;
      end
      // Pin sampling at state nine and state ten
      if (st_reg.phase == qbio_pkg::STATE_NINE) begin
        st_next.samp_od = sy_od;
        st_next.samp_one = sy_one;
      end
      if (st_reg.phase == qbio_pkg::STATE_TEN) begin
        st_next.samp_ha = sy_ha;
        st_next.samp_three = sy_three;
      end
    end
    // Register writes from the data bus
    if (port_wr) begin
      unique case (port_sel)
        qbio_pkg::PORT_OD: st_next.latch_od = wr_data;
        qbio_pkg::PORT_ONE: st_next.latch_one = wr_data;
        qbio_pkg::PORT_HA: st_next.latch_ha = wr_data;
        qbio_pkg::PORT_THREE: st_next.latch_three = wr_data;
        qbio_pkg::PORT_FOUR: st_next.latch_four = wr_data[3:0];
        default: st_next.latch_od = st_next.latch_od;
      endcase
    end
    // Bus mode forces the open-drain register high; high-address keeps
    if (bus_mode) begin
      st_next.latch_od = qbio_pkg::ALL_ONES;
    end
    // Read either the register or the sampled pin
    unique case (port_sel)
      qbio_pkg::PORT_OD: st_next.rd = rd_pin_sel ? st_reg.samp_od
                                                 : st_reg.latch_od;
      qbio_pkg::PORT_ONE: st_next.rd = rd_pin_sel ? st_reg.samp_one
                                                  : st_reg.latch_one;
      qbio_pkg::PORT_HA: st_next.rd = rd_pin_sel ? st_reg.samp_ha
                                                 : st_reg.latch_ha;
      qbio_pkg::PORT_THREE: st_next.rd = rd_pin_sel ? st_reg.samp_three
                                                    : st_reg.latch_three;
      qbio_pkg::PORT_FOUR: st_next.rd = rd_pin_sel ?
          qbio_widen(st_reg.samp_four) : qbio_widen(st_reg.latch_four);
      default: st_next.rd = 8'h00;
    endcase
    // External bus read data straight from the synchronised pins
    st_next.bus_rd = sy_od;
  end

  // State register
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      st_reg <= '0;
      st_reg.phase <= qbio_pkg::STATE_FIRST;
      st_reg.latch_od <= qbio_pkg::PORT_RESET;
      st_reg.latch_one <= qbio_pkg::PORT_RESET;
      st_reg.latch_ha <= qbio_pkg::PORT_RESET;
      st_reg.latch_three <= qbio_pkg::PORT_RESET;
      st_reg.latch_four <= qbio_pkg::PORT_RESET[3:0];
      st_reg.stage_od <= qbio_pkg::PORT_RESET;
      st_reg.stage_one <= qbio_pkg::PORT_RESET;
      st_reg.stage_ha <= qbio_pkg::PORT_RESET;
      st_reg.stage_three <= qbio_pkg::PORT_RESET;
      st_reg.stage_four <= qbio_pkg::PORT_RESET[3:0];
      st_reg.samp_od <= qbio_pkg::PORT_RESET;
      st_reg.samp_one <= qbio_pkg::PORT_RESET;
      st_reg.samp_ha <= qbio_pkg::PORT_RESET;
      st_reg.samp_three <= qbio_pkg::PORT_RESET;
      st_reg.samp_four <= qbio_pkg::PORT_RESET[3:0];
      st_reg.bus_rd <= qbio_pkg::PORT_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  // Quasi-bidirectional ports: pull-down on a zero bit, weak pull-up off-chip
  assign port_one_out = 8'h00;
  assign port_one_oe_n = st_reg.stage_one;
  assign port_three_out = 8'h00;
  assign port_three_oe_n = st_reg.stage_three;
  assign port_four_out = 4'h0;
  assign port_four_oe_n = st_reg.stage_four;

  // High-address port: register or A8-A15 driven hard in bus mode
  assign high_address_port_out = bus_mode ? bus_addr_hi : 8'h00;
  assign high_address_port_oe_n = bus_mode ? 8'h00
                                           : st_reg.stage_ha;

  // Open-drain port: floats on a one bit, active drive only in bus mode
  always_comb begin
    if (bus_mode && bus_addr_phase) begin
      open_drain_bus_port_out = bus_addr_lo;
      open_drain_bus_port_oe_n = 8'h00;
    end else if (bus_mode && bus_drive) begin
      open_drain_bus_port_out = bus_wr_data;
      open_drain_bus_port_oe_n = 8'h00;
    end else if (bus_mode) begin
      open_drain_bus_port_out = 8'h00;
      open_drain_bus_port_oe_n = qbio_pkg::ALL_ONES;
    end else begin
      open_drain_bus_port_out = 8'h00;
      open_drain_bus_port_oe_n = st_reg.stage_od;
    end
  end
  // Active pull-up marker only in bus mode
  assign open_drain_bus_port_pullup = bus_mode ? qbio_pkg::ALL_ONES
                                               : 8'h00;

  assign rd_data = st_reg.rd;
  assign bus_rd_data = st_reg.bus_rd;
  assign machine_state = st_reg.phase;
endmodule

// ===== qbio_ports_chk.sv
// Checker for machine-state timing and bus-mode outputs of the ports
`timescale 1ns/1ps
module qbio_ports_chk (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic osc_state_en,
  input wire logic [2:0] port_sel,
  input wire logic external_access_select,
  input wire logic external_data_move,
  input wire logic bus_addr_phase,
  input wire logic [7:0] bus_addr_lo,
  input wire logic [7:0] bus_addr_hi,
  input wire logic [7:0] rd_data,
  input wire logic [7:0] open_drain_bus_port_out,
  input wire logic [7:0] open_drain_bus_port_pullup,
  input wire logic [7:0] port_one_oe_n,
  input wire logic [7:0] high_address_port_out,
  input wire logic [7:0] high_address_port_oe_n,
  input wire logic [3:0] machine_state
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  logic bm;
  // External bus mode as the core selects it
  assign bm = !external_access_select || external_data_move;
  // Machine state steps and wraps on each enable
  state_wrap_a: assert property (
    osc_state_en && machine_state == 4'hC |=> machine_state == 4'h1)
    else $error("machine state did not wrap");
  state_step_a: assert property (
    osc_state_en && machine_state != 4'hC
    |=> machine_state == $past(machine_state) + 4'h1)
    else $error("machine state did not step");
  // Port one pin enables move only at the end of the final state
  oe_edge_a: assert property (
    $changed(port_one_oe_n)
    |-> $past(machine_state) == 4'hC && $past(osc_state_en))
    else $error("pin enable changed outside the final state");
  // Active pull-up follows bus mode only
  pullup_on_a: assert property (
    bm |-> open_drain_bus_port_pullup == 8'hFF)
    else $error("pull-up off in bus mode");
  pullup_off_a: assert property (
    !bm |-> open_drain_bus_port_pullup == 8'h00)
    else $error("pull-up on outside bus mode");
  // Bus mode takes the output stages away from the registers
  ha_bus_a: assert property (
    bm |-> high_address_port_out == bus_addr_hi
    && high_address_port_oe_n == 8'h00)
    else $error("high address port not on the bus");
  od_addr_a: assert property (
    bm && bus_addr_phase |-> open_drain_bus_port_out == bus_addr_lo)
    else $error("low address missing on open-drain port");
  // The narrow port reads back zeros above its four lines
  nib_read_a: assert property (
    port_sel == 3'h4 |=> rd_data[7:4] == 4'h0)
    else $error("narrow port read has upper bits set");
endmodule

bind qbio_ports qbio_ports_chk chk_u (.clock(clock), .rst_n(rst_n),
  .osc_state_en(osc_state_en), .port_sel(port_sel), .rd_data(rd_data),
  .external_access_select(external_access_select),
  .external_data_move(external_data_move), .bus_addr_phase(bus_addr_phase),
  .bus_addr_lo(bus_addr_lo), .bus_addr_hi(bus_addr_hi),
  .open_drain_bus_port_out(open_drain_bus_port_out),
  .open_drain_bus_port_pullup(open_drain_bus_port_pullup),
  .port_one_oe_n(port_one_oe_n), .machine_state(machine_state),
  .high_address_port_out(high_address_port_out),
  .high_address_port_oe_n(high_address_port_oe_n));

// ===== qbio_pins.sv
// Pin model: pull-ups, floating open-drain lines and outside drivers
`timescale 1ns/1ps
module qbio_pins #(
  parameter int W = 8,
  parameter bit PULL = 1'b1
) (
  input wire logic clock,
  input wire logic [W-1:0] out,
  input wire logic [W-1:0] oe_n,
  input wire logic [W-1:0] pull_en,
  input wire logic [W-1:0] ext_en,
  input wire logic [W-1:0] ext_val,
  output logic [W-1:0] pin
);
  logic [W-1:0] drift = '0;
  // A floating line shows a level that flips every cycle
  always @(posedge clock) drift <= ~drift;
  // Device sink wins, then outside driver, then pull-up, else float
  always_comb begin
    for (int i = 0; i < W; i++) begin
      if (!oe_n[i]) pin[i] = out[i];
      else if (ext_en[i]) pin[i] = ext_val[i];
      else if (PULL || pull_en[i]) pin[i] = 1'b1;
      else pin[i] = drift[i];
    end
  end
endmodule

// ===== qbio_ports_test.sv
// Self-checking bench for the quasi-bidirectional port block
`timescale 1ns/1ps
module qbio_ports_test;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic en = 1'b1, wr_s = 1'b0, pin_s = 1'b0, ea = 1'b1, edm = 1'b0;
  logic aph = 1'b0, bdr = 1'b0;
  logic [2:0] sel = 3'h0;
  logic [7:0] wd = 8'h00, alo = 8'h00, ahi = 8'h00, bwd = 8'h00;
  logic [4:0][7:0] xe = '0, xv = '0, pin, po, poe;
  logic [7:0] rdd, brd, od_pu;
  logic [3:0] mst;
  int bad_count = 0;
  int check_count = 0;
  initial forever #20 clock = ~clock;
  qbio_ports dut_u (.clock(clock), .rst_n(rst_n), .osc_state_en(en),
    .port_sel(sel), .port_wr(wr_s), .wr_data(wd), .rd_pin_sel(pin_s),
    .rd_data(rdd), .external_access_select(ea), .external_data_move(edm),
    .bus_addr_phase(aph), .bus_drive(bdr), .bus_addr_lo(alo),
    .bus_addr_hi(ahi), .bus_wr_data(bwd), .bus_rd_data(brd),
    .open_drain_bus_port_in(pin[0]), .open_drain_bus_port_out(po[0]),
    .open_drain_bus_port_oe_n(poe[0]), .open_drain_bus_port_pullup(od_pu),
    .port_one_in(pin[1]), .port_one_out(po[1]), .port_one_oe_n(poe[1]),
    .high_address_port_in(pin[2]), .high_address_port_out(po[2]),
    .high_address_port_oe_n(poe[2]), .port_three_in(pin[3]),
    .port_three_out(po[3]), .port_three_oe_n(poe[3]),
    .port_four_in(pin[4][3:0]), .port_four_out(po[4][3:0]),
    .port_four_oe_n(poe[4][3:0]), .machine_state(mst));
  assign po[4][7:4] = 4'h0;
  assign poe[4][7:4] = 4'h0;
  // Lines of the five ports; only the open-drain port floats
  for (genvar g = 0; g < 5; g++) begin : pins_g
    localparam int W = g == 4 ? 4 : 8;
    qbio_pins #(.W(W), .PULL(g != 0)) m_u (.clock(clock), .out(po[g][W-1:0]),
      .oe_n(poe[g][W-1:0]), .pull_en(g == 0 ? od_pu[W-1:0] : '0),
      .ext_en(xe[g][W-1:0]), .ext_val(xv[g][W-1:0]), .pin(pin[g][W-1:0]));
  end
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clock);
    #2;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [2:0] p, input logic [7:0] d);
    sel = p;
    wd = d;
    wr_s = 1'b1;
    step(1);
    wr_s = 1'b0;
    step(1);
  endtask
  task automatic rd(input logic [2:0] p, input logic s, input logic [7:0] e);
    sel = p;
    pin_s = s;
    step(1);
    chk(rdd, e);
  endtask
  task automatic wait_st(input logic [3:0] v);
    int n;
    n = 0;
    while (mst !== v && n < 40) begin
      step(1);
      n++;
    end
    if (mst !== v) begin
      bad_count++;
      tally_and_finish();
    end
  endtask
  // Everything an input with pull-down off, after either reset
  task automatic t_reset;
    for (int p = 0; p < 5; p++) begin
      chk(poe[p], p == 4 ? 8'h0F : 8'hFF);
      rd(3'(p), 1'b0, p == 4 ? 8'h0F : 8'hFF);
    end
    $display("test reset done");
  endtask
  // Register takes the write at once, the pin after the final state
  task automatic t_write;
    logic [3:0][7:0] d;
    d = {8'h06, 8'h3C, 8'hA5, 8'h5A};
    for (int i = 0; i < 4; i++) begin
      wait_st(4'h1);
      wr(3'(i + 1), d[i]);
      rd(3'(i + 1), 1'b0, d[i]);
      wait_st(4'hC);
      chk(poe[i + 1], i == 3 ? 8'h0F : 8'hFF);
      step(1);
      chk(poe[i + 1], d[i]);
    end
    wr(3'h7, 8'h00);
    rd(3'h1, 1'b0, 8'h5A);
    $display("test write done");
  endtask
  // Pin reads differ from register reads, except on port three, where the sinks hold the pins at F0
  task automatic t_pin;
    wr(3'h1, 8'hFF);
    wr(3'h3, 8'hF0);
    xe = {8'h0F, 8'h0F, 8'h00, 8'hFF, 8'hFF};
    xv = {8'h09, 8'h05, 8'h00, 8'h96, 8'hC3};
    step(40);
    rd(3'h1, 1'b1, 8'h96);
    rd(3'h1, 1'b0, 8'hFF);
    rd(3'h3, 1'b1, 8'hF0);
    rd(3'h0, 1'b1, 8'hC3);
    rd(3'h4, 1'b1, 8'h00);
    xe = '0;
    $display("test pin done");
  endtask
  // Open-drain sink, then both ports taken over by the bus
  task automatic t_bus;
    wait_st(4'h1);
    wr(3'h0, 8'h00);
    wait_st(4'hC);
    step(1);
    chk(pin[0], 8'h00);
    ea = 1'b0;
    aph = 1'b1;
    alo = 8'h12;
    ahi = 8'h34;
    step(1);
    chk(po[0], 8'h12);
    chk(po[2], 8'h34);
    aph = 1'b0;
    bdr = 1'b1;
    bwd = 8'h77;
    step(1);
    chk(po[0], 8'h77);
    bdr = 1'b0;
    xe[0] = 8'hFF;
    xv[0] = 8'hC3;
    step(3);
    chk(brd, 8'hC3);
    wr(3'h0, 8'h00);
    rd(3'h0, 1'b0, 8'hFF);
    rd(3'h2, 1'b0, 8'hA5);
    ea = 1'b1;
    edm = 1'b1;
    wr(3'h0, 8'h55);
    chk(od_pu, 8'hFF);
    rd(3'h0, 1'b0, 8'hFF);
    edm = 1'b0;
    xe = '0;
    wr(3'h0, 8'h55);
    rd(3'h0, 1'b0, 8'h55);
    $display("test bus done");
  endtask
  initial begin
    step(16);
    rst_n = 1'b1;
    t_reset();
    t_write();
    t_pin();
    t_bus();
    rst_n = 1'b0;
    step(2);
    rst_n = 1'b1;
    t_reset();
    tally_and_finish();
  end
endmodule
